// ==== hw/csidt_timing_regs.sv ====
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/100ps

// Operation
// - Manual select low uses derived value, high uses programmed 7-bit value; resets low.
// - With manual select low, value field ignores writes and reads the derived value.
// - With manual select high, value field is writable and reads back the written value.
// - Derived values follow the selected line rate; reset matches 800 Mbps.
// - Clock post-time value field resets to 0xA with automatic selection.
// - HS prepare-time control sits at index 0x64, resets to 0x06.
// - HS zero-time control sits at index 0x65, resets to 0x0C.
// - HS trail-time control sits at index 0x66, resets to 0x08.
// - HS exit-time control sits at index 0x67, resets to 0x0B.
// - LP transmit-time control sits at index 0x68, resets to 0x06.
// - Clock post-time control sits at index 0x63, resets to 0x0A.
module csidt_timing_regs (
    input wire logic sys_clk,
    input wire logic rst,
    input wire csidt_pkg::csidt_avs_req_type avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [2:0] line_rate,
    input wire logic [5:0] lane_state_enter,
    output logic [5:0][6:0] lane_duration
);

    // ****************************************************************
    // State and derived values
    // ****************************************************************
    csidt_pkg::csidt_state_type s_q;
    csidt_pkg::csidt_state_type s_d;
    logic [5:0][6:0] auto_value;
    logic [5:0][6:0] sel_value;
    logic [5:0] param_hit;
    logic rate_hit;
    logic [31:0] read_word;

    // Per-parameter decode and value selection
    genvar gi;
    generate
        for (gi = 0; gi < csidt_pkg::CSIDT_NUM_PARAMS; gi++) begin : g_param
            // Table lookup, rate is kept within the table rows
            assign auto_value[gi] = csidt_pkg::CSIDT_AUTO_TABLE[s_q.rate][gi];
            // Manual select picks the stored field
            assign sel_value[gi] = s_q.manual[gi] ? s_q.value[gi] : auto_value[gi];
            // Index decode, low address bits must be zero
            assign param_hit[gi] = (avs_req.address[9:2] == csidt_pkg::CSIDT_PARAM_IDX[gi])
                && (avs_req.address[1:0] == 2'h0);
        end
    endgenerate

    assign rate_hit = (avs_req.address[9:2] == csidt_pkg::CSIDT_IDX_LINE_RATE)
        && (avs_req.address[1:0] == 2'h0);

    // ****************************************************************
    // Read mux
    // ****************************************************************
    // Unmapped words read as zero; value field shows the selected value
    always_comb begin
        read_word = 32'h0000_0000;
        for (int k = 0; k < csidt_pkg::CSIDT_NUM_PARAMS; k++) begin
            if (param_hit[k]) begin
                read_word = {24'h00_0000, s_q.manual[k], sel_value[k]};
            end
        end
        if (rate_hit) begin
            read_word = {29'h0000_0000, s_q.rate};
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Bus handshake, register writes and lane duration capture
    always_comb begin
        s_d = s_q;
        case (s_q.phase)
            csidt_pkg::CSIDT_IDLE: begin
                // One wait cycle keeps both bus outputs registered
                if (avs_req.read || avs_req.write) begin
                    s_d.phase = csidt_pkg::CSIDT_ACK;
                    s_d.waitrequest = 1'b0;
                    s_d.readdata = avs_req.read ? read_word : 32'h0000_0000;
                end
            end
            csidt_pkg::CSIDT_ACK: begin
                s_d.phase = csidt_pkg::CSIDT_IDLE;
                s_d.waitrequest = 1'b1;
                s_d.readdata = 32'h0000_0000;
                // Write lands on the edge that sees waitrequest low
                if (avs_req.write && avs_req.byteenable[0]) begin
                    for (int k = 0; k < csidt_pkg::CSIDT_NUM_PARAMS; k++) begin
                        if (param_hit[k]) begin
                            s_d.manual[k] = avs_req.writedata[csidt_pkg::CSIDT_MANUAL_BIT];
                            // Field only taken while manual select is set
                            if (avs_req.writedata[csidt_pkg::CSIDT_MANUAL_BIT]) begin
                                s_d.value[k] = avs_req.writedata[6:0];
                            end
                        end
                    end
                    // Codes beyond the table are refused, rate stays
                    if (rate_hit && (avs_req.writedata[2:0] <= csidt_pkg::CSIDT_RATE_MAX)) begin
                        s_d.rate = avs_req.writedata[2:0];
                    end
                end
            end
            default: begin
                s_d.phase = csidt_pkg::CSIDT_IDLE;
                s_d.waitrequest = 1'b1;
            end
        endcase
        // A changed value waits for the next entry into its state
        for (int k = 0; k < csidt_pkg::CSIDT_NUM_PARAMS; k++) begin
            if (lane_state_enter[k]) begin
                s_d.duration[k] = sel_value[k];
            end
        end
        // Synchronous reset to the 800 Mbps defaults
        if (rst) begin
            s_d.phase = csidt_pkg::CSIDT_IDLE;
            s_d.waitrequest = 1'b1;
            s_d.readdata = 32'h0000_0000;
            s_d.rate = csidt_pkg::CSIDT_RST_RATE;
            for (int k = 0; k < csidt_pkg::CSIDT_NUM_PARAMS; k++) begin
                s_d.manual[k] = csidt_pkg::CSIDT_RST_REG[k][7];
                s_d.value[k] = csidt_pkg::CSIDT_RST_REG[k][6:0];
                s_d.duration[k] = csidt_pkg::CSIDT_RST_REG[k][6:0];
            end
        end
    end

    // ****************************************************************
    // State register and outputs
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        s_q <= s_d;
    end

    // Outputs come straight from the state register
    assign avs_readdata = s_q.readdata;
    assign avs_waitrequest = s_q.waitrequest;
    assign line_rate = s_q.rate;
    assign lane_duration = s_q.duration;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    logic ack_q;
    assign ack_q = (s_q.phase == csidt_pkg::CSIDT_ACK);

    // ****************************************************************
    // Per-parameter guards
    // ****************************************************************
    // Same guards on every column, so a slip in one parameter shows up
    genvar ai;
    generate
        for (ai = 0; ai < csidt_pkg::CSIDT_NUM_PARAMS; ai++) begin : g_check
            // Select bit moves only on an accepted write
            manual_hold_a: assert property (
                !(ack_q && avs_req.write) |=> $stable(s_q.manual[ai]))
                else $error("manual select moved without a write");

            // Stored field moves only on a write that sets manual select
            value_hold_a: assert property (
                !(ack_q && avs_req.write && avs_req.byteenable[0] && param_hit[ai]
                    && avs_req.writedata[7]) |=> $stable(s_q.value[ai]))
                else $error("stored value moved without a manual write");

            // Entry pulse loads the value selected at that edge
            entry_load_a: assert property (
                lane_state_enter[ai] |=> lane_duration[ai] == $past(sel_value[ai]))
                else $error("lane duration not loaded on entry");

            // Without an entry pulse the running count stays put
            entry_hold_a: assert property (
                !lane_state_enter[ai] |=> $stable(lane_duration[ai]))
                else $error("lane duration moved without entry");
        end
    endgenerate

    // ****************************************************************
    // Bus and map guards
    // ****************************************************************
    // Idle bus keeps waitrequest high and read data cleared
    idle_bus_a: assert property (
        (s_q.phase == csidt_pkg::CSIDT_IDLE) |-> avs_waitrequest && (avs_readdata == 32'h0000_0000))
        else $error("idle bus outputs wrong");

    // Answer phase always drops waitrequest
    ack_phase_a: assert property (
        ack_q |-> !avs_waitrequest)
        else $error("answer phase without waitrequest low");

    // Only the low byte carries data
    read_upper_a: assert property (
        avs_readdata[31:8] == 24'h00_0000)
        else $error("upper read bytes not zero");

    // Rate code never leaves the table rows
    rate_range_a: assert property (
        line_rate <= csidt_pkg::CSIDT_RATE_MAX)
        else $error("rate code out of table");

    // Refused rate codes leave the rate untouched
    rate_refused_a: assert property (
        ack_q && avs_req.write && avs_req.byteenable[0] && rate_hit
            && (avs_req.writedata[2:0] > csidt_pkg::CSIDT_RATE_MAX)
            |=> $stable(line_rate))
        else $error("refused rate code taken");

    // Upper byte lanes alone write nothing
    byte_lane_a: assert property (
        ack_q && avs_req.write && !avs_req.byteenable[0]
            |=> $stable(s_q.manual) && $stable(s_q.value) && $stable(s_q.rate))
        else $error("write without low byte lane took effect");

    // Misaligned byte address reaches no register
    misaligned_a: assert property (
        ack_q && avs_req.write && (avs_req.address[1:0] != 2'h0)
            |=> $stable(s_q.manual) && $stable(s_q.value) && $stable(s_q.rate))
        else $error("misaligned write took effect");

    // Rate word reads back the current code
    rate_read_a: assert property (
        (s_q.phase == csidt_pkg::CSIDT_IDLE) && avs_req.read && rate_hit
            |=> avs_readdata == {29'h0000_0000, $past(s_q.rate)})
        else $error("rate word read wrong");

    // Each index from HS prepare to LP transmit reads its 800 Mbps default in automatic mode
    prepare_index_a: assert property (
        (s_q.phase == csidt_pkg::CSIDT_IDLE) && avs_req.read && (avs_req.address == 10'h190)
            && !s_q.manual[1] && (s_q.rate == csidt_pkg::CSIDT_RATE_800)
            |=> avs_readdata == 32'h0000_0006)
        else $error("prepare index read wrong");

    zero_index_a: assert property (
        (s_q.phase == csidt_pkg::CSIDT_IDLE) && avs_req.read && (avs_req.address == 10'h194)
            && !s_q.manual[2] && (s_q.rate == csidt_pkg::CSIDT_RATE_800)
            |=> avs_readdata == 32'h0000_000C)
        else $error("zero index read wrong");

    trail_index_a: assert property (
        (s_q.phase == csidt_pkg::CSIDT_IDLE) && avs_req.read && (avs_req.address == 10'h198)
            && !s_q.manual[3] && (s_q.rate == csidt_pkg::CSIDT_RATE_800)
            |=> avs_readdata == 32'h0000_0008)
        else $error("trail index read wrong");

    exit_index_a: assert property (
        (s_q.phase == csidt_pkg::CSIDT_IDLE) && avs_req.read && (avs_req.address == 10'h19C)
            && !s_q.manual[4] && (s_q.rate == csidt_pkg::CSIDT_RATE_800)
            |=> avs_readdata == 32'h0000_000B)
        else $error("exit index read wrong");

    transmit_index_a: assert property (
        (s_q.phase == csidt_pkg::CSIDT_IDLE) && avs_req.read && (avs_req.address == 10'h1A0)
            && !s_q.manual[5] && (s_q.rate == csidt_pkg::CSIDT_RATE_800)
            |=> avs_readdata == 32'h0000_0006)
        else $error("transmit index read wrong");

    // Reset leaves automatic selection and 800 Mbps values
    reset_defaults_a: assert property (@(posedge sys_clk) disable iff (1'b0)
        rst |=> (s_q.manual == 6'h00) && (s_q.rate == csidt_pkg::CSIDT_RST_RATE)
            && (s_q.value[0] == 7'h0A) && (s_q.value[1] == 7'h06) && (s_q.value[2] == 7'h0C)
            && (s_q.value[3] == 7'h08) && (s_q.value[4] == 7'h0B) && (s_q.value[5] == 7'h06))
        else $error("register reset values wrong");

    // A request is answered after exactly one wait cycle
    bus_answer_a: assert property (
        (s_q.phase == csidt_pkg::CSIDT_IDLE) && (avs_req.read || avs_req.write)
            |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest timing wrong");

    // Clock post read at its index in automatic mode
    post_auto_read_a: assert property (
        (s_q.phase == csidt_pkg::CSIDT_IDLE) && avs_req.read && (avs_req.address == 10'h18C)
            && !s_q.manual[0]
            |=> avs_readdata == {25'h000_0000, $past(auto_value[0])})
        else $error("clock post auto read wrong");

    // Derived value returned while manual select is clear
    auto_read_a: assert property (
        (s_q.phase == csidt_pkg::CSIDT_IDLE) && avs_req.read && param_hit[2] && !s_q.manual[2]
            |=> avs_readdata[7:0] == {1'b0, csidt_pkg::CSIDT_AUTO_TABLE[$past(s_q.rate)][2]})
        else $error("auto value not returned");

    // Written value returned while manual select is set
    manual_read_a: assert property (
        (s_q.phase == csidt_pkg::CSIDT_IDLE) && avs_req.read && param_hit[1] && s_q.manual[1]
            |=> avs_readdata[7:0] == {1'b1, $past(s_q.value[1])})
        else $error("manual value not returned");

    // Field write without manual select is dropped
    write_ignored_a: assert property (
        ack_q && avs_req.write && avs_req.byteenable[0] && param_hit[3]
            && !avs_req.writedata[7]
            |=> !s_q.manual[3] && (s_q.value[3] == $past(s_q.value[3])))
        else $error("write reached read-only field");

    // Field write with manual select is stored
    write_taken_a: assert property (
        ack_q && avs_req.write && avs_req.byteenable[0] && param_hit[4] && avs_req.writedata[7]
            |=> s_q.manual[4] && (s_q.value[4] == $past(avs_req.writedata[6:0])))
        else $error("manual write lost");

    // Entering a state loads the selected value
    duration_load_a: assert property (
        lane_state_enter[5]
            |=> lane_duration[5] == ($past(s_q.manual[5]) ? $past(s_q.value[5])
                : $past(auto_value[5])))
        else $error("lane duration not loaded");

    // Duration holds until the next entry
    duration_hold_a: assert property (
        !lane_state_enter[0] |=> $stable(lane_duration[0]))
        else $error("lane duration changed without entry");

    // Rate change moves the derived values
    rate_follow_a: assert property (
        ack_q && avs_req.write && avs_req.byteenable[0] && rate_hit
            && (avs_req.writedata[2:0] == csidt_pkg::CSIDT_RATE_1600)
            |=> (line_rate == csidt_pkg::CSIDT_RATE_1600)
                && (auto_value[1] == csidt_pkg::CSIDT_AUTO_TABLE[4][1]))
        else $error("derived values did not follow rate");

    // Main scenarios
    cover_manual_write_c: cover property (
        ack_q && avs_req.write && (|param_hit) && avs_req.writedata[7]);
    cover_rate_change_c: cover property (
        ack_q && avs_req.write && rate_hit ##1 $changed(line_rate));
    cover_auto_read_c: cover property (
        ack_q && avs_req.read && (|param_hit) ##0 !avs_readdata[7]);
    cover_lane_entry_c: cover property (
        lane_state_enter[0] ##1 $changed(lane_duration[0]));

endmodule

// ==== hw/csidt_pkg.sv ====
package csidt_pkg;

    // ****************************************************************
    // Register map: printed offsets are register indices,
    // byte address is four times the index
    // ****************************************************************
    localparam int CSIDT_NUM_PARAMS = 6;
    localparam logic [7:0] CSIDT_IDX_CLOCK_POST = 8'h63;
    localparam logic [7:0] CSIDT_IDX_HS_PREPARE = 8'h64;
    localparam logic [7:0] CSIDT_IDX_HS_ZERO = 8'h65;
    localparam logic [7:0] CSIDT_IDX_HS_TRAIL = 8'h66;
    localparam logic [7:0] CSIDT_IDX_HS_EXIT = 8'h67;
    localparam logic [7:0] CSIDT_IDX_LP_TRANSMIT = 8'h68;
    localparam logic [7:0] CSIDT_IDX_LINE_RATE = 8'h69;

    // Parameter order used by every per-parameter array
    localparam logic [0:5][7:0] CSIDT_PARAM_IDX = '{
        CSIDT_IDX_CLOCK_POST, CSIDT_IDX_HS_PREPARE, CSIDT_IDX_HS_ZERO,
        CSIDT_IDX_HS_TRAIL, CSIDT_IDX_HS_EXIT, CSIDT_IDX_LP_TRANSMIT};

    // ****************************************************************
    // Field layout and reset values
    // ****************************************************************
    localparam int CSIDT_MANUAL_BIT = 7;
    localparam int CSIDT_VALUE_W = 7;
    localparam int CSIDT_RATE_W = 3;
    localparam logic [7:0] CSIDT_RST_CLOCK_POST = 8'h0A;
    localparam logic [7:0] CSIDT_RST_HS_PREPARE = 8'h06;
    localparam logic [7:0] CSIDT_RST_HS_ZERO = 8'h0C;
    localparam logic [7:0] CSIDT_RST_HS_TRAIL = 8'h08;
    localparam logic [7:0] CSIDT_RST_HS_EXIT = 8'h0B;
    localparam logic [7:0] CSIDT_RST_LP_TRANSMIT = 8'h06;
    localparam logic [0:5][7:0] CSIDT_RST_REG = '{
        CSIDT_RST_CLOCK_POST, CSIDT_RST_HS_PREPARE, CSIDT_RST_HS_ZERO,
        CSIDT_RST_HS_TRAIL, CSIDT_RST_HS_EXIT, CSIDT_RST_LP_TRANSMIT};

    // ****************************************************************
    // Line rate codes and derived timing table
    // ****************************************************************
    localparam logic [2:0] CSIDT_RATE_400 = 3'h0;
    localparam logic [2:0] CSIDT_RATE_800 = 3'h1;
    localparam logic [2:0] CSIDT_RATE_1200 = 3'h2;
    localparam logic [2:0] CSIDT_RATE_1500 = 3'h3;
    localparam logic [2:0] CSIDT_RATE_1600 = 3'h4;
    localparam logic [2:0] CSIDT_RATE_MAX = CSIDT_RATE_1600;
    localparam logic [2:0] CSIDT_RST_RATE = CSIDT_RATE_800;

    // Rows by rate code, columns in parameter order
    localparam logic [0:4][0:5][6:0] CSIDT_AUTO_TABLE = '{
        '{7'h05, 7'h03, 7'h06, 7'h04, 7'h06, 7'h03},
        '{CSIDT_RST_CLOCK_POST[6:0], CSIDT_RST_HS_PREPARE[6:0], CSIDT_RST_HS_ZERO[6:0],
          CSIDT_RST_HS_TRAIL[6:0], CSIDT_RST_HS_EXIT[6:0], CSIDT_RST_LP_TRANSMIT[6:0]},
        '{7'h0F, 7'h09, 7'h12, 7'h0C, 7'h10, 7'h09},
        '{7'h13, 7'h0B, 7'h16, 7'h0F, 7'h14, 7'h0B},
        '{7'h14, 7'h0C, 7'h18, 7'h10, 7'h16, 7'h0C}};

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [0:0] {CSIDT_IDLE, CSIDT_ACK} csidt_phase_type;

    typedef struct packed {
        logic [9:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } csidt_avs_req_type;

    typedef struct packed {
        csidt_phase_type phase;
        logic waitrequest;
        logic [31:0] readdata;
        logic [2:0] rate;
        logic [5:0] manual;
        logic [5:0][6:0] value;
        logic [5:0][6:0] duration;
    } csidt_state_type;

endpackage

// ==== bench/csidt_timing_regs_test.sv ====
`timescale 1ns/100ps

module csidt_timing_regs_test;

    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    csidt_pkg::csidt_avs_req_type req = '0;
    logic [5:0] lane_state_enter = 6'h00;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [2:0] line_rate;
    logic [5:0][6:0] lane_duration;
    int fails = 0;
    int checked = 0;
    // Reset words in parameter order: post, prepare, zero, trail, exit, lp transmit
    logic [7:0] rst_word [6] = '{8'h0A, 8'h06, 8'h0C, 8'h08, 8'h0B, 8'h06};

    csidt_timing_regs dut (
        .sys_clk(sys_clk),
        .rst(rst),
        .avs_req(req),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .line_rate(line_rate),
        .lane_state_enter(lane_state_enter),
        .lane_duration(lane_duration)
    );

    // 50 ns period
    always #25 sys_clk = ~sys_clk;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
            fails++;
        end
    endtask

    // One Avalon cycle; entered right after a rising edge, leaves one idle cycle behind
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic [3:0] be, output logic [31:0] rd);
        int n;
        n = 0;
        req.address <= {idx, 2'b00};
        req.read <= !wr;
        req.write <= wr;
        req.writedata <= {24'h000000, wd};
        req.byteenable <= be;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        if (n >= 50) begin
            check("waitrequest", {31'h0, avs_waitrequest}, 32'h00000000);
        end
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, 4'hF, d);
    endtask

    task automatic rd_check(input string name, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 8'h00, 4'hF, d);
        check(name, d, exp);
    endtask

    // Pulse every lane state entry, then compare all durations
    task automatic lane_check(input logic [6:0] exp [6]);
        lane_state_enter <= 6'h3F;
        @(posedge sys_clk);
        lane_state_enter <= 6'h00;
        @(posedge sys_clk);
        for (int k = 0; k < 6; k++) begin
            check("lane_duration", {25'h0, lane_duration[k]}, {25'h0, exp[k]});
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        logic [6:0] e [6];
        for (int k = 0; k < 6; k++) begin
            rd_check("reset word", 8'h63 + k[7:0], {24'h0, rst_word[k]});
            e[k] = rst_word[k][6:0];
        end
        rd_check("rate word", 8'h69, 32'h00000001);
        check("line_rate", {29'h0, line_rate}, 32'h00000001);
        lane_check(e);
    endtask

    // Value field stays read-only while manual select is clear
    task automatic t_readonly();
        logic [31:0] d;
        for (int k = 0; k < 6; k++) begin
            wr_reg(8'h63 + k[7:0], 8'h55);
            bus(1'b1, 8'h63 + k[7:0], 8'hD5, 4'hE, d);
            rd_check("ignored write", 8'h63 + k[7:0], {24'h0, rst_word[k]});
        end
    endtask

    // Manual values back to back, then back to automatic
    task automatic t_manual();
        logic [6:0] e [6];
        for (int k = 0; k < 6; k++) begin
            wr_reg(8'h63 + k[7:0], 8'hA0 + k[7:0]);
            e[k] = 7'h20 + k[6:0];
        end
        for (int k = 0; k < 6; k++) begin
            rd_check("manual word", 8'h63 + k[7:0], 32'h000000A0 + k);
        end
        lane_check(e);
        for (int k = 0; k < 6; k++) begin
            wr_reg(8'h63 + k[7:0], 8'h00);
            rd_check("auto again", 8'h63 + k[7:0], {24'h0, rst_word[k]});
            e[k] = rst_word[k][6:0];
        end
        lane_check(e);
    endtask

    // Every rate code, an illegal code second to last, ending on the reset rate
    task automatic t_rate();
        logic [6:0] e [6];
        logic [2:0] codes [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h7, 3'h1};
        logic [2:0] want;
        want = 3'h1;
        for (int i = 0; i < 6; i++) begin
            wr_reg(8'h69, {5'h00, codes[i]});
            if (codes[i] <= 3'h4) want = codes[i];
            check("line_rate", {29'h0, line_rate}, {29'h0, want});
            for (int k = 0; k < 6; k++) begin
                e[k] = csidt_pkg::CSIDT_AUTO_TABLE[want][k];
                rd_check("derived", 8'h63 + k[7:0], {25'h0, e[k]});
            end
            lane_check(e);
        end
    endtask

    // Unmapped index reads zero and swallows writes
    task automatic t_unmapped();
        wr_reg(8'h70, 8'hFF);
        rd_check("unmapped", 8'h70, 32'h00000000);
        rd_check("neighbour", 8'h68, 32'h00000006);
    endtask

    // ****************************************************************
    // Verdict, main sequence and watchdog
    // ****************************************************************
    task automatic summarize();
        if (fails == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_readonly();
        t_manual();
        t_rate();
        t_unmapped();
        summarize();
    end

    // Whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        summarize();
    end

endmodule
